// ### core/wdt_pkg.sv
// Purpose: Shared constants for the watchdog with prewarning
// Assumes: 100 MHz ref_clk, 32-bit Avalon-MM register port
// Notes: Byte addresses, reset values and command codes live here
package wdt_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRE_W = 14;
  localparam int unsigned ADDR_W = 5;
  // Register byte addresses
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CMD = 5'h04;
  localparam logic [4:0] OFF_RELOAD = 5'h08;
  localparam logic [4:0] OFF_COUNT = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  // Field positions
  localparam int unsigned CTRL_SEL_BIT = 0;
  localparam int unsigned STAT_EN_BIT = 0;
  localparam int unsigned STAT_WARN_BIT = 1;
  localparam int unsigned STAT_RST_BIT = 2;
  // Command codes written to the command register
  localparam logic [1:0] CMD_SERVICE = 2'h1;
  localparam logic [1:0] CMD_OFF = 2'h2;
  localparam logic [1:0] CMD_ON = 2'h3;
  // Divider settings: select 0 gives 16384, select 1 gives 256
  localparam logic [13:0] DIV_SLOW_LAST = 14'h3fff;
  localparam logic [13:0] DIV_FAST_LAST = 14'h00ff;
  // Reset values: 255 ticks of 256 cycles is about 6.5 ms at 10 MHz
  localparam logic RST_SEL = 1'b1;
  localparam logic [15:0] RST_RELOAD = 16'hff01;
  localparam logic RST_ENABLE = 1'b1;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // Gap between prewarning and reset request
  localparam int unsigned PREWARN_TIME_NS = 2560;
  localparam int unsigned PREWARN_CYCLES = (PREWARN_TIME_NS * CLK_MHZ) / 1000;
  typedef enum logic [1:0] {
    WDT_RUN = 2'b00,
    WDT_WARN = 2'b01,
    WDT_RESET = 2'b10
  } wdt_state_t;
endpackage : wdt_pkg

// ### core/wdt_prescaler.sv
// Purpose: Clearable system clock divider for the watchdog
// Assumes: Single clock, terminal value chosen by the caller
// Notes: tick is high in the last cycle of each division period
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler #(
  parameter int unsigned WIDTH = 14
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic clear,
  input wire logic [WIDTH-1:0] last,
  output logic tick
);
  logic [WIDTH-1:0] div_q;
  logic [WIDTH-1:0] div_d;

  initial begin
    if (WIDTH < 8) begin
      $error("wdt_prescaler: WIDTH too small");
    end
  end

  assign tick = run && !clear && (div_q >= last);
  assign div_d = (clear || tick) ? '0 : (run ? div_q + WIDTH'(1) : div_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end
endmodule // wdt_prescaler
`default_nettype wire

// ### core/wdt_top.sv
// Purpose: Watchdog timer with prewarning and reset request
// Assumes: Avalon-MM slave on ref_clk, one access answered per two cycles
// Notes: Prewarning and reset request stay high until rst_n
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01 - After reset the watchdog is enabled and counting with no software action.
// RULE_02 - Software may disable or enable the watchdog at any time by command.
// RULE_03 - Software must service the watchdog before the counter overflows.
// RULE_04 - Unserviced overflow raises prewarning first, then a reset request.
// RULE_05 - The watchdog count is a 16-bit timer register.
// RULE_06 - Counter advances on system clock divided by 16384 or 256, software selected.
// RULE_07 - Counter loads from a programmable reload register to set the interval.
// RULE_08 - Each service copies reload into counter and clears the prescaler together.
// RULE_09 - Reset settings give about 6.5 ms interval at 10 MHz.
// RULE_10 - Counter increments per prescaler tick; overflow is the wrap from all ones.
module wdt_top #(
  parameter int unsigned CNT_WIDTH = wdt_pkg::CNT_W,
  parameter int unsigned WARN_CYCLES = wdt_pkg::PREWARN_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [wdt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic prewarn_irq,
  output logic reset_req
);
  initial begin
    if (CNT_WIDTH != 16) begin
      $error("wdt_top: counter must be 16 bits wide");
    end
    if (WARN_CYCLES < 1 || WARN_CYCLES > 4096) begin
      $error("wdt_top: WARN_CYCLES out of range");
    end
  end

  // Bus handshake and decode
  logic ack_q;
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_cmd;
  logic hit_reload;
  logic hit_count;
  logic hit_status;
  logic lo_lane;
  logic hi_lane;

  // Control and state
  logic sel_q;
  logic [15:0] reload_q;
  logic en_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [11:0] warn_cnt_q;
  logic [11:0] warn_cnt_d;
  wdt_pkg::wdt_state_t state_q;
  wdt_pkg::wdt_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Commands and timer events
  logic [1:0] cmd_code;
  logic do_service;
  logic do_off;
  logic do_on;
  logic tick;
  logic overflow;
  logic [13:0] div_last;
  logic warn_done;
  logic [15:0] reload_d;

  // One wait cycle per access so readdata comes from a flop
  assign access = (avs_read || avs_write) && !ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_en = avs_write && ack_q;
  assign rd_en = avs_read && !ack_q;

  assign hit_ctrl = (avs_address == wdt_pkg::OFF_CTRL);
  assign hit_cmd = (avs_address == wdt_pkg::OFF_CMD);
  assign hit_reload = (avs_address == wdt_pkg::OFF_RELOAD);
  assign hit_count = (avs_address == wdt_pkg::OFF_COUNT);
  assign hit_status = (avs_address == wdt_pkg::OFF_STATUS);
  assign lo_lane = avs_byteenable[0];
  assign hi_lane = avs_byteenable[1];

  // RULE_02 command decode
  assign cmd_code = avs_writedata[1:0];
  assign do_service = wr_en && hit_cmd && lo_lane && (cmd_code == wdt_pkg::CMD_SERVICE);
  assign do_off = wr_en && hit_cmd && lo_lane && (cmd_code == wdt_pkg::CMD_OFF);
  assign do_on = wr_en && hit_cmd && lo_lane && (cmd_code == wdt_pkg::CMD_ON);

  // RULE_07 byte-lane reload write
  assign reload_d = (wr_en && hit_reload) ?
                    {hi_lane ? avs_writedata[15:8] : reload_q[15:8],
                     lo_lane ? avs_writedata[7:0] : reload_q[7:0]} :
                    reload_q;

  // RULE_06 divider terminal select
  assign div_last = sel_q ? wdt_pkg::DIV_FAST_LAST : wdt_pkg::DIV_SLOW_LAST;

  // RULE_08 service clears prescaler
  wdt_prescaler #(
    .WIDTH(wdt_pkg::PRE_W)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(en_q),
    .clear(do_service),
    .last(div_last),
    .tick(tick)
  );

  // RULE_10 wrap from all ones
  assign overflow = tick && (cnt_q == wdt_pkg::CNT_MAX);

  // RULE_08 reload on service wins over a tick
  // RULE_05 16-bit count
  assign cnt_d = do_service ? reload_q : (tick ? cnt_q + 16'h0001 : cnt_q);

  assign warn_done = (warn_cnt_q == 12'(WARN_CYCLES - 1));

  // RULE_04 prewarning then reset request
  always_comb begin
    state_d = state_q;
    warn_cnt_d = warn_cnt_q;
    unique case (state_q)
      wdt_pkg::WDT_RUN: begin
        warn_cnt_d = '0;
        if (overflow) begin
          state_d = wdt_pkg::WDT_WARN;
        end
      end
      wdt_pkg::WDT_WARN: begin
        if (warn_done) begin
          state_d = wdt_pkg::WDT_RESET;
        end else begin
          warn_cnt_d = warn_cnt_q + 12'h001;
        end
      end
      wdt_pkg::WDT_RESET: begin
        state_d = wdt_pkg::WDT_RESET;
      end
      default: begin
        state_d = wdt_pkg::WDT_RESET;
      end
    endcase
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_d[wdt_pkg::CTRL_SEL_BIT] = sel_q;
    end else if (hit_reload) begin
      rdata_d[15:0] = reload_q;
    end else if (hit_count) begin
      rdata_d[15:0] = cnt_q;
    end else if (hit_status) begin
      rdata_d[wdt_pkg::STAT_EN_BIT] = en_q;
      rdata_d[wdt_pkg::STAT_WARN_BIT] = (state_q != wdt_pkg::WDT_RUN);
      rdata_d[wdt_pkg::STAT_RST_BIT] = (state_q == wdt_pkg::WDT_RESET);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= access;
      if (rd_en) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // RULE_09 reset defaults
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= wdt_pkg::RST_SEL;
      reload_q <= wdt_pkg::RST_RELOAD;
    end else begin
      if (wr_en && hit_ctrl && lo_lane) begin
        sel_q <= avs_writedata[wdt_pkg::CTRL_SEL_BIT];
      end
      reload_q <= reload_d;
    end
  end

  // RULE_01 enabled out of reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= wdt_pkg::RST_ENABLE;
    end else if (do_off) begin
      en_q <= 1'b0;
    end else if (do_on) begin
      en_q <= 1'b1;
    end
  end

  // RULE_09 counter starts at the reload value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= wdt_pkg::RST_RELOAD;
      state_q <= wdt_pkg::WDT_RUN;
      warn_cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
      state_q <= state_d;
      warn_cnt_q <= warn_cnt_d;
    end
  end

  // Once raised, only rst_n drops these; a late service cannot hide a failure
  assign prewarn_irq = (state_q != wdt_pkg::WDT_RUN);
  assign reset_req = (state_q == wdt_pkg::WDT_RESET);
  assign avs_readdata = rdata_q;
endmodule // wdt_top
`default_nettype wire

// ### verification/wdt_props.sv
// Purpose: Port-level checks for the watchdog
// Assumes: Bound to wdt_top, one clock
// Notes: Gap counter measures prewarning to reset request
`timescale 1ns/1ps
`default_nettype none
module wdt_props #(
  parameter int unsigned WARN_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic prewarn_irq,
  input wire logic reset_req
);
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  assign gap_d = prewarn_irq ? gap_q + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) gap_q <= 16'h0000;
    else gap_q <= gap_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  AST_IDLE_NO_WAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  AST_WARN_STAYS: assert property (prewarn_irq |=> prewarn_irq)
    else $error("prewarning dropped");
  AST_RST_STAYS: assert property (reset_req |=> reset_req)
    else $error("reset request dropped");
  AST_RST_AFTER_WARN: assert property (reset_req |-> prewarn_irq)
    else $error("reset request without prewarning");
  AST_RST_GAP: assert property ($rose(reset_req) |-> gap_q == WARN_CYCLES)
    else $error("wrong gap before reset request");
  AST_UNMAP_ZERO: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RELOAD_UPPER: assert property (avs_read && !avs_waitrequest && avs_address == 5'h08 |->
    avs_readdata[31:16] == 16'h0000)
    else $error("reload upper bits not zero");
endmodule // wdt_props
bind wdt_top wdt_props #(.WARN_CYCLES(WARN_CYCLES)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .prewarn_irq(prewarn_irq), .reset_req(reset_req));
`default_nettype wire

// ### verification/tb_wdt_top.sv
// Purpose: Self-checking bench for the watchdog
// Assumes: Short prewarning gap of 4 cycles
// Notes: Timeout test leaves its flags set; a mid-run reset then clears them
`timescale 1ns/1ps
`default_nettype none
module tb_wdt_top;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, prewarn_irq, reset_req;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  wdt_top #(.WARN_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prewarn_irq(prewarn_irq), .reset_req(reset_req));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is sampled low; only the hang guard ends a wait
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input string n, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    cmp(n, e, q);
  endtask
  task automatic t_reset();
    rd(5'h00, "ctrl", 32'h1);
    rd(5'h08, "reload", 32'hff01);
    rd(5'h0c, "count", 32'hff01);
    rd(5'h10, "status", 32'h1);
    rd(5'h14, "unmapped", 32'h0);
    $display("test reset done");
  endtask
  task automatic t_reload();
    acc(1'b1, 5'h08, 32'h1234);
    rd(5'h08, "reload", 32'h1234);
    // Upper lane only: low byte must survive
    avs_byteenable <= 4'h2;
    acc(1'b1, 5'h08, 32'hab00);
    rd(5'h08, "reload", 32'hab34);
    avs_byteenable <= 4'hf;
    acc(1'b1, 5'h08, 32'h1234);
    acc(1'b1, 5'h04, 32'h1);
    rd(5'h0c, "count", 32'h1234);
    // Read lands just before the first tick, only true if the divider was cleared
    repeat (240) @(posedge ref_clk);
    rd(5'h0c, "count", 32'h1234);
    repeat (20) @(posedge ref_clk);
    rd(5'h0c, "count", 32'h1235);
    $display("test reload done");
  endtask
  task automatic t_off();
    acc(1'b1, 5'h04, 32'h1);
    acc(1'b1, 5'h04, 32'h2);
    repeat (600) @(posedge ref_clk);
    rd(5'h0c, "count", 32'h1234);
    rd(5'h10, "status", 32'h0);
    // Code zero is not a command and must not switch the watchdog on
    acc(1'b1, 5'h04, 32'h0);
    rd(5'h10, "status", 32'h0);
    acc(1'b1, 5'h04, 32'h3);
    repeat (300) @(posedge ref_clk);
    rd(5'h0c, "count", 32'h1235);
    $display("test off done");
  endtask
  task automatic t_slow();
    acc(1'b1, 5'h00, 32'h0);
    acc(1'b1, 5'h04, 32'h1);
    repeat (600) @(posedge ref_clk);
    rd(5'h0c, "count", 32'h1234);
    repeat (16000) @(posedge ref_clk);
    rd(5'h0c, "count", 32'h1235);
    acc(1'b1, 5'h00, 32'h1);
    $display("test slow done");
  endtask
  task automatic t_timeout();
    acc(1'b1, 5'h08, 32'hfffe);
    acc(1'b1, 5'h04, 32'h1);
    repeat (500) @(posedge ref_clk);
    cmp("prewarn", 32'h0, {31'h0, prewarn_irq});
    repeat (24) @(posedge ref_clk);
    cmp("prewarn", 32'h1, {31'h0, prewarn_irq});
    cmp("reset_req", 32'h1, {31'h0, reset_req});
    rd(5'h0c, "count", 32'h0);
    rd(5'h10, "status", 32'h7);
    $display("test timeout done");
  endtask
  // Application reset after a failure must clear the flags and rearm the watchdog
  task automatic t_rearm();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp("prewarn", 32'h0, {31'h0, prewarn_irq});
    cmp("reset_req", 32'h0, {31'h0, reset_req});
    rst_n <= 1'b1;
    rd(5'h10, "status", 32'h1);
    rd(5'h00, "ctrl", 32'h1);
    rd(5'h0c, "count", 32'hff01);
    $display("test rearm done");
  endtask
  // Hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_reload();
    t_off();
    t_slow();
    t_timeout();
    t_rearm();
    end_of_test();
  end
endmodule // tb_wdt_top
`default_nettype wire
